// ---- nrate_timing_protection_select_tb.sv ----
/* Testbench joining the switch end and module end over the link.
   Assumes a 20 MHz clock and the package constants. */
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module nrate_timing_protection_select_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic odd_unit_fail = 1'b0;
    logic even_unit_fail = 1'b0;
    logic ref_ok = 1'b1;
    logic fast_request = 1'b0;
    logic free_run_request = 1'b0;
    logic [15:0] phase_error = 16'h0000;
    logic [15:0] local_osc_word = 16'h1234;
    logic synchronizer_fault = 1'b0;
    logic repair_done = 1'b0;
    logic [1:0] force_protection = 2'h0;
    logic [1:0] fclk_return_seen;
    logic [1:0] sync_return_seen;
    logic [15:0] master_freq_word;
    logic master_clk;
    logic [1:0] sync_mode;
    logic holdover_entered;
    logic synchronizer_in_service;
    logic oscillator_far_end_fail;
    logic [7:0] odd_iface_fclk;
    logic [7:0] odd_iface_fsync;
    logic [7:0] even_iface_fclk;
    logic [7:0] even_iface_fsync;
    logic [1:0] using_protection;
    logic [15:0] fw;
    logic m;
    int err_total = 0;
    int comparisons = 0;
    int n;
    logic [1:0] tbl [6] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h0, 2'h3};
    always #25 clk = ~clk;
    // ****************************************
    // Ends and checker
    // ****************************************
    nrt_link_if link ();
    nrt_switch_end #(.SYNC_DIV(16)) nrt_switch_end_inst (.clk(clk), .rst_b(rst_b),
        .odd_unit_fail(odd_unit_fail), .even_unit_fail(even_unit_fail), .link(link),
        .fclk_return_seen(fclk_return_seen), .sync_return_seen(sync_return_seen));
    nrt_module_end nrt_module_end_inst (.clk(clk), .rst_b(rst_b), .link(link), .ref_ok(ref_ok),
        .fast_request(fast_request), .free_run_request(free_run_request), .phase_error(phase_error),
        .local_osc_word(local_osc_word), .synchronizer_fault(synchronizer_fault),
        .repair_done(repair_done), .force_protection(force_protection),
        .master_freq_word(master_freq_word), .master_clk(master_clk), .sync_mode(sync_mode),
        .holdover_entered(holdover_entered), .synchronizer_in_service(synchronizer_in_service),
        .oscillator_far_end_fail(oscillator_far_end_fail), .odd_iface_fclk(odd_iface_fclk),
        .odd_iface_fsync(odd_iface_fsync), .even_iface_fclk(even_iface_fclk),
        .even_iface_fsync(even_iface_fsync), .using_protection(using_protection));
    nrt_link_props nrt_link_props_inst (.clk(clk), .rst_b(rst_b),
        .odd_fclk_to_svc(link.odd_fclk_to_svc), .odd_fsync_to_svc(link.odd_fsync_to_svc),
        .even_fclk_to_svc(link.even_fclk_to_svc), .even_fsync_to_svc(link.even_fsync_to_svc),
        .odd_fclk_to_prot(link.odd_fclk_to_prot), .odd_fsync_to_prot(link.odd_fsync_to_prot),
        .even_fclk_to_prot(link.even_fclk_to_prot), .even_fsync_to_prot(link.even_fsync_to_prot),
        .odd_io_protected(link.odd_io_protected), .even_io_protected(link.even_io_protected),
        .fclk_return(link.fclk_return), .fsync_return(link.fsync_return),
        .active_distributor(link.active_distributor));
    // ****************************************
    // Tasks
    // ****************************************
    task cyc(input int k);
        repeat (k) @(negedge clk);
    endtask : cyc
    task fan_chk(input logic [1:0] up);
        logic a;
        logic b;
        logic c;
        logic d;
        repeat (6) begin
            // Five cycles a pass so the sample walks through every clock phase
            cyc(2);
            a = up[0] ? link.odd_fclk_to_prot : link.odd_fclk_to_svc;
            b = up[1] ? link.even_fclk_to_prot : link.even_fclk_to_svc;
            c = up[0] ? link.odd_fsync_to_prot : link.odd_fsync_to_svc;
            d = up[1] ? link.even_fsync_to_prot : link.even_fsync_to_svc;
            cyc(3);
            `CHK(odd_iface_fclk, {8{a}})
            `CHK(even_iface_fclk, {8{b}})
            `CHK(odd_iface_fsync, {8{c}})
            `CHK(even_iface_fsync, {8{d}})
        end
    endtask : fan_chk
    task final_report;
        $display("Comparisons %0d, errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        cyc(5);
        `CHK(sync_mode, nrt_pkg::MODE_FAST)
        cyc(45);
        `CHK(sync_mode, nrt_pkg::MODE_NORMAL)
        m = master_clk;
        cyc(1);
        `CHK(master_clk, ~m)
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            {even_unit_fail, odd_unit_fail} <= (i == 6) ? 2'h0 : tbl[i];
            cyc(60);
            `CHK(using_protection, (i < 5) ? tbl[i] : 2'h0)
            `CHK(link.active_distributor, (i < 5) ? tbl[i] : 2'h0)
            fan_chk((i < 5) ? tbl[i] : 2'h0);
        end
        for (int i = 2; i >= 0; i--) begin
            @(posedge clk);
            force_protection <= 2'(i);
            cyc(60);
            `CHK(using_protection, 2'(i))
            fan_chk(2'(i));
        end
        n = 0;
        repeat (16) begin
            m = fclk_return_seen[0];
            cyc(1);
            if (fclk_return_seen[0] !== m) n++;
        end
        `CHK(n != 0, 1'b1)
        n = 0;
        repeat (16 * nrt_pkg::LINK_DIV) begin
            cyc(1);
            if (sync_return_seen == 2'h3) n++;
        end
        `CHK(n, nrt_pkg::LINK_DIV)
        @(posedge clk);
        ref_ok <= 1'b0;
        cyc(2);
        `CHK(holdover_entered, 1'b1)
        `CHK(sync_mode, nrt_pkg::MODE_HOLDOVER)
        cyc(1);
        `CHK(holdover_entered, 1'b0)
        fw = master_freq_word;
        @(posedge clk);
        phase_error <= 16'h0100;
        cyc(8);
        `CHK(master_freq_word, fw)
        @(posedge clk);
        free_run_request <= 1'b1;
        cyc(3);
        `CHK(sync_mode, nrt_pkg::MODE_FREE_RUN)
        @(posedge clk);
        phase_error <= 16'h0020;
        cyc(8);
        `CHK(master_freq_word, local_osc_word)
        @(posedge clk);
        free_run_request <= 1'b0;
        ref_ok <= 1'b1;
        cyc(3);
        `CHK(sync_mode, nrt_pkg::MODE_FAST)
        cyc(45);
        `CHK(sync_mode, nrt_pkg::MODE_NORMAL)
        @(posedge clk);
        fast_request <= 1'b1;
        cyc(3);
        `CHK(sync_mode, nrt_pkg::MODE_FAST)
        @(posedge clk);
        fast_request <= 1'b0;
        synchronizer_fault <= 1'b1;
        cyc(3);
        `CHK({synchronizer_in_service, oscillator_far_end_fail}, 2'h1)
        @(posedge clk);
        synchronizer_fault <= 1'b0;
        repair_done <= 1'b1;
        cyc(3);
        `CHK({synchronizer_in_service, oscillator_far_end_fail}, 2'h2)
        @(posedge clk);
        repair_done <= 1'b0;
        final_report();
    end
    initial begin
        #(50 * 8000);
        err_total++;
        final_report();
    end
endmodule : nrate_timing_protection_select_tb

// ---- nrt_link_if.sv ----
/*
 * Link between the switch-side end and the interface-module end.
 * Assumes the bench joins the two modports; no two-way pins.
 */
`timescale 1ns/100ps
interface nrt_link_if;
    logic odd_fclk_to_svc;
    logic odd_fsync_to_svc;
    logic even_fclk_to_svc;
    logic even_fsync_to_svc;
    logic odd_fclk_to_prot;
    logic odd_fsync_to_prot;
    logic even_fclk_to_prot;
    logic even_fsync_to_prot;
    logic odd_io_protected;
    logic even_io_protected;
    logic [1:0] fclk_return;
    logic [1:0] fsync_return;
    logic [1:0] active_distributor;
    modport switch_end (
        output odd_fclk_to_svc, odd_fsync_to_svc, even_fclk_to_svc, even_fsync_to_svc,
        output odd_fclk_to_prot, odd_fsync_to_prot, even_fclk_to_prot, even_fsync_to_prot,
        output odd_io_protected, even_io_protected,
        input fclk_return, fsync_return, active_distributor
    );
    modport module_end (
        input odd_fclk_to_svc, odd_fsync_to_svc, even_fclk_to_svc, even_fsync_to_svc,
        input odd_fclk_to_prot, odd_fsync_to_prot, even_fclk_to_prot, even_fsync_to_prot,
        input odd_io_protected, even_io_protected,
        output fclk_return, fsync_return, active_distributor
    );
endinterface : nrt_link_if

// ---- nrt_link_props.sv ----
/* Checker for the framing timing link between the two ends.
   Assumes the bench instantiates it beside the link interface. */
`timescale 1ns/100ps
module nrt_link_props (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic odd_fclk_to_svc,
    input wire logic odd_fsync_to_svc,
    input wire logic even_fclk_to_svc,
    input wire logic even_fsync_to_svc,
    input wire logic odd_fclk_to_prot,
    input wire logic odd_fsync_to_prot,
    input wire logic even_fclk_to_prot,
    input wire logic even_fsync_to_prot,
    input wire logic odd_io_protected,
    input wire logic even_io_protected,
    input wire logic [1:0] fclk_return,
    input wire logic [1:0] fsync_return,
    input wire logic [1:0] active_distributor
);
    // ****************************************
    // Settling count after reset
    // ****************************************
    logic [2:0] up_r;
    wire logic settled = (up_r == 3'h7);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            up_r <= 3'h0;
        end else if (up_r != 3'h7) begin
            up_r <= up_r + 3'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ****************************************
    // Properties
    // ****************************************
    sequence odd_feed_stuck;
        (!odd_io_protected && $stable(odd_fclk_to_svc)) [*8];
    endsequence
    sequence odd_goes_prot;
        $rose(odd_io_protected);
    endsequence
    one_protected_a: assert property (!(odd_io_protected && even_io_protected))
        else $error("both units protected");
    odd_switch_a: assert property (odd_goes_prot |-> ##[1:40] active_distributor[0])
        else $error("odd module did not move to protection");
    even_switch_a: assert property ($rose(even_io_protected) |-> ##[1:40] active_distributor[1])
        else $error("even module did not move to protection");
    odd_return_a: assert property (settled |-> fclk_return[0] == $past(odd_fclk_to_svc, 4))
        else $error("odd clock return wrong");
    even_sync_return_a: assert property (settled |-> fsync_return[1] == $past(even_fsync_to_svc, 4))
        else $error("even sync return wrong");
    odd_to_even_a: assert property (!odd_io_protected && !even_io_protected |-> even_fclk_to_prot == odd_fclk_to_svc)
        else $error("even protection feed not from odd unit");
    even_to_odd_a: assert property (!odd_io_protected && !even_io_protected |-> odd_fsync_to_prot == even_fsync_to_svc)
        else $error("odd protection sync not from even unit");
    feed_live_a: assert property (settled |-> not odd_feed_stuck)
        else $error("odd service clock stopped");
endmodule : nrt_link_props

// ---- nrt_module_end.sv ----
/*
 * Interface-module end: phase-lock synchronizer mode control, stratum
 * oscillator service coupling, and the two framing clock distributors of the
 * odd and even modules feeding the switch interface units.
 * Assumes framing clock and sync arrive asynchronously from the switch end.
 */
`timescale 1ns/100ps
// What this block does
// - Synchronizer holds exactly one of four modes
// - Normal mode tracks reference with full filtering
// - Fast mode acquires lock quickly
// - Reference failure enters holdover, keeps last normal-mode frequency
// - Free-run fixes frequency from local oscillator
// - Synchronizer out of service faults oscillator; restore together
// - Same hardware version on one side
// - Distributors accept framing clock and sync, fan out
// - One distributor service, other protection, eight units
// - Distributors return re-timed clock and sync
// - Normally timing from service distributor, own unit
// - Odd unit protects even module, even protects odd
// - A lone failed unit moves module timing to protection; with both failed neither moves
// - Traffic distributor chosen from unit active states
// - Operator moves traffic before distributor removal
// - Unit pair serves sixteen groups
// - Protection group covers up to 31 working
// - Controller drives serial links and LAN
// - Synchronizer makes master clock toward clock generators
module nrt_module_end #(
    parameter int NUM_IFACE = nrt_pkg::NUM_IFACE,
    parameter int FREQ_W = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    nrt_link_if.module_end link,
    input wire logic ref_ok,
    input wire logic fast_request,
    input wire logic free_run_request,
    input wire logic [FREQ_W-1:0] phase_error,
    input wire logic [FREQ_W-1:0] local_osc_word,
    input wire logic synchronizer_fault,
    input wire logic repair_done,
    input wire logic [1:0] force_protection,
    output logic [FREQ_W-1:0] master_freq_word,
    output logic master_clk,
    output logic [1:0] sync_mode,
    output logic holdover_entered,
    output logic synchronizer_in_service,
    output logic oscillator_far_end_fail,
    output logic [NUM_IFACE-1:0] odd_iface_fclk,
    output logic [NUM_IFACE-1:0] odd_iface_fsync,
    output logic [NUM_IFACE-1:0] even_iface_fclk,
    output logic [NUM_IFACE-1:0] even_iface_fsync,
    output logic [1:0] using_protection
);
    nrt_pkg::nrt_mode_t mode_r;
    logic [7:0] lock_cnt_r;
    logic [FREQ_W-1:0] good_freq_r;
    logic out_of_service_r;
    logic mclk_r;
    // Inputs in order: odd svc, odd prot, even svc, even prot, odd-prot flag, even-prot flag
    logic [9:0] in_s1_r, in_s2_r, in_s3_r;
    logic [1:0] want_prot;
    logic [1:0] sel_r;
    logic [1:0] gap_r;
    logic [1:0] gap_cnt_r [0:1];

    // ************************************************************
    // Synchronizer mode control
    // ************************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_r <= nrt_pkg::NRT_FAST;
            lock_cnt_r <= 8'h00;
            holdover_entered <= 1'b0;
        end else begin
            holdover_entered <= 1'b0;
            case (mode_r)
                nrt_pkg::NRT_NORMAL: begin
                    if (free_run_request) begin
                        mode_r <= nrt_pkg::NRT_FREE_RUN;
                    end else if (!ref_ok) begin
                        mode_r <= nrt_pkg::NRT_HOLDOVER;
                        holdover_entered <= 1'b1;
                    end else if (fast_request) begin
                        mode_r <= nrt_pkg::NRT_FAST;
                        lock_cnt_r <= 8'h00;
                    end
                end
                nrt_pkg::NRT_FAST: begin
                    if (free_run_request) begin
                        mode_r <= nrt_pkg::NRT_FREE_RUN;
                    end else if (!ref_ok) begin
                        mode_r <= nrt_pkg::NRT_HOLDOVER;
                        holdover_entered <= 1'b1;
                    end else if (lock_cnt_r == 8'(nrt_pkg::LOCK_CYCLES - 1)) begin
                        mode_r <= nrt_pkg::NRT_NORMAL;
                    end else begin
                        lock_cnt_r <= lock_cnt_r + 8'h01;
                    end
                end
                nrt_pkg::NRT_HOLDOVER: begin
                    if (free_run_request) begin
                        mode_r <= nrt_pkg::NRT_FREE_RUN;
                    end else if (ref_ok) begin
                        mode_r <= nrt_pkg::NRT_FAST;
                        lock_cnt_r <= 8'h00;
                    end
                end
                nrt_pkg::NRT_FREE_RUN: begin
                    if (!free_run_request && ref_ok) begin
                        mode_r <= nrt_pkg::NRT_FAST;
                        lock_cnt_r <= 8'h00;
                    end
                end
                default: mode_r <= nrt_pkg::NRT_FREE_RUN;
            endcase
        end
    end
    assign sync_mode = mode_r;

    // ************************************************************
    // Frequency word: full filter, fast gain, hold, free-run
    // ************************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            master_freq_word <= '0;
            good_freq_r <= '0;
        end else begin
            case (mode_r)
                nrt_pkg::NRT_NORMAL: begin
                    master_freq_word <= master_freq_word + FREQ_W'($signed(phase_error) >>> 4);
                    good_freq_r <= master_freq_word;
                end
                nrt_pkg::NRT_FAST: begin
                    master_freq_word <= master_freq_word + FREQ_W'($signed(phase_error) >>> 1);
                end
                nrt_pkg::NRT_HOLDOVER: master_freq_word <= good_freq_r;
                nrt_pkg::NRT_FREE_RUN: master_freq_word <= local_osc_word;
                default: master_freq_word <= local_osc_word;
            endcase
        end
    end

    // Master clock toward the clock generators
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mclk_r <= 1'b0;
        end else begin
            mclk_r <= ~mclk_r;
        end
    end
    assign master_clk = mclk_r;

    // ************************************************************
    // Service state coupling with stratum oscillator
    // ************************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_of_service_r <= 1'b0;
        end else if (synchronizer_fault) begin
            out_of_service_r <= 1'b1;
        end else if (repair_done) begin
            out_of_service_r <= 1'b0;
        end
    end
    assign synchronizer_in_service = ~out_of_service_r;
    assign oscillator_far_end_fail = out_of_service_r;

    // ************************************************************
    // Link input synchronisers
    // ************************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            in_s1_r <= 10'h000;
            in_s2_r <= 10'h000;
            in_s3_r <= 10'h000;
        end else begin
            in_s1_r <= {link.even_io_protected, link.odd_io_protected,
                        link.even_fsync_to_prot, link.even_fclk_to_prot,
                        link.even_fsync_to_svc, link.even_fclk_to_svc,
                        link.odd_fsync_to_prot, link.odd_fclk_to_prot,
                        link.odd_fsync_to_svc, link.odd_fclk_to_svc};
            in_s2_r <= in_s1_r;
            in_s3_r <= in_s2_r;
        end
    end

    // ************************************************************
    // Distributor selection with dead gap between sources
    // ************************************************************
    assign want_prot[0] = in_s2_r[8] | force_protection[0];
    assign want_prot[1] = in_s2_r[9] | force_protection[1];

    genvar m;
    generate
        for (m = 0; m < 2; m++) begin : g_mod
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    sel_r[m] <= 1'b0;
                    gap_r[m] <= 1'b0;
                    gap_cnt_r[m] <= 2'h0;
                end else if (gap_r[m]) begin
                    // Hold clock output low until the gap count ends and both clock copies are low, then swap
                    if (gap_cnt_r[m] == 2'(nrt_pkg::GAP_CYCLES - 1) && !in_s2_r[4*m] && !in_s2_r[4*m+2]) begin
                        sel_r[m] <= want_prot[m];
                        gap_r[m] <= 1'b0;
                    end else if (gap_cnt_r[m] != 2'(nrt_pkg::GAP_CYCLES - 1)) begin
                        gap_cnt_r[m] <= gap_cnt_r[m] + 2'h1;
                    end
                end else if (want_prot[m] != sel_r[m] && !(sel_r[m] ? in_s2_r[4*m+2] : in_s2_r[4*m])) begin
                    gap_r[m] <= 1'b1;
                    gap_cnt_r[m] <= 2'h0;
                end
            end
        end
    endgenerate

    // ************************************************************
    // Fan-out to the switch interface units
    // ************************************************************
    logic odd_clk_sel, odd_sync_sel, even_clk_sel, even_sync_sel;
    assign odd_clk_sel = ~gap_r[0] & (sel_r[0] ? in_s2_r[2] : in_s2_r[0]);
    assign odd_sync_sel = sel_r[0] ? in_s2_r[3] : in_s2_r[1];
    assign even_clk_sel = ~gap_r[1] & (sel_r[1] ? in_s2_r[6] : in_s2_r[4]);
    assign even_sync_sel = sel_r[1] ? in_s2_r[7] : in_s2_r[5];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            odd_iface_fclk <= '0;
            odd_iface_fsync <= '0;
            even_iface_fclk <= '0;
            even_iface_fsync <= '0;
        end else begin
            odd_iface_fclk <= {NUM_IFACE{odd_clk_sel}};
            odd_iface_fsync <= {NUM_IFACE{odd_sync_sel}};
            even_iface_fclk <= {NUM_IFACE{even_clk_sel}};
            even_iface_fsync <= {NUM_IFACE{even_sync_sel}};
        end
    end
    assign using_protection = sel_r;

    // Re-timed copies back to the switch side
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            link.fclk_return <= 2'h0;
            link.fsync_return <= 2'h0;
            link.active_distributor <= 2'h0;
        end else begin
            link.fclk_return <= {in_s3_r[4], in_s3_r[0]};
            link.fsync_return <= {in_s3_r[5], in_s3_r[1]};
            link.active_distributor <= sel_r;
        end
    end
endmodule : nrt_module_end

// ---- nrt_pkg.sv ----
/*
 * Shared constants and types for the framing timing select block.
 * Assumes a 20 MHz system clock on both ends.
 */
package nrt_pkg;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int NUM_IFACE = 8;
    localparam int LINK_DIV = 4;
    localparam int MODE_W = 2;
    localparam int LOCK_TIME_NS = 2000;
    localparam int LOCK_CYCLES = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CYCLES = 2;
    localparam int IOPAIR_GROUPS = 16;
    localparam int PROT_MAX_WORKING = 31;
    localparam int PROT_OWN_GROUPS = 7;
    localparam logic [MODE_W-1:0] MODE_NORMAL = 2'h0;
    localparam logic [MODE_W-1:0] MODE_FAST = 2'h1;
    localparam logic [MODE_W-1:0] MODE_HOLDOVER = 2'h2;
    localparam logic [MODE_W-1:0] MODE_FREE_RUN = 2'h3;
    typedef enum logic [1:0] {
        NRT_NORMAL = 2'b00,
        NRT_FAST = 2'b01,
        NRT_HOLDOVER = 2'b10,
        NRT_FREE_RUN = 2'b11
    } nrt_mode_t;
endpackage : nrt_pkg

// ---- nrt_switch_end.sv ----
/*
 * Switch-side end: the odd/even switch I/O unit pair. Divides the system
 * clock into framing clock and sync and feeds service and protection copies.
 * Assumes the module end is joined through nrt_link_if.
 */
`timescale 1ns/100ps
module nrt_switch_end #(
    parameter int SYNC_DIV = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic odd_unit_fail,
    input wire logic even_unit_fail,
    nrt_link_if.switch_end link,
    output logic [1:0] fclk_return_seen,
    output logic [1:0] sync_return_seen
);
    logic [7:0] div_r;
    logic fclk_r;
    logic fsync_r;
    logic odd_prot_r;
    logic even_prot_r;
    logic [1:0] rclk_s1_r, rclk_s2_r, rsync_s1_r, rsync_s2_r;

    // ************************************************************
    // Framing clock and sync generation
    // ************************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_r <= 8'h00;
            fclk_r <= 1'b0;
            fsync_r <= 1'b0;
        end else begin
            if (div_r == 8'((SYNC_DIV * nrt_pkg::LINK_DIV) - 1)) begin
                div_r <= 8'h00;
            end else begin
                div_r <= div_r + 8'h01;
            end
            if (div_r[1:0] == 2'h1 || div_r[1:0] == 2'h3) begin
                fclk_r <= ~fclk_r;
            end
            fsync_r <= (div_r < 8'(nrt_pkg::LINK_DIV));
        end
    end

    // ************************************************************
    // Failure of one unit alone moves traffic to the mate; both failing moves none
    // ************************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            odd_prot_r <= 1'b0;
            even_prot_r <= 1'b0;
        end else begin
            odd_prot_r <= odd_unit_fail & ~even_unit_fail;
            even_prot_r <= even_unit_fail & ~odd_unit_fail;
        end
    end

    // Each unit feeds its own module's service input and the mate's protection input
    assign link.odd_fclk_to_svc = fclk_r & ~odd_prot_r;
    assign link.odd_fsync_to_svc = fsync_r & ~odd_prot_r;
    assign link.even_fclk_to_svc = fclk_r & ~even_prot_r;
    assign link.even_fsync_to_svc = fsync_r & ~even_prot_r;
    assign link.even_fclk_to_prot = fclk_r & ~odd_prot_r;
    assign link.even_fsync_to_prot = fsync_r & ~odd_prot_r;
    assign link.odd_fclk_to_prot = fclk_r & ~even_prot_r;
    assign link.odd_fsync_to_prot = fsync_r & ~even_prot_r;
    assign link.odd_io_protected = odd_prot_r;
    assign link.even_io_protected = even_prot_r;

    // ************************************************************
    // Re-timed return sampling
    // ************************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rclk_s1_r <= 2'h0;
            rclk_s2_r <= 2'h0;
            rsync_s1_r <= 2'h0;
            rsync_s2_r <= 2'h0;
            fclk_return_seen <= 2'h0;
            sync_return_seen <= 2'h0;
        end else begin
            rclk_s1_r <= link.fclk_return;
            rclk_s2_r <= rclk_s1_r;
            rsync_s1_r <= link.fsync_return;
            rsync_s2_r <= rsync_s1_r;
            fclk_return_seen <= rclk_s2_r;
            sync_return_seen <= rsync_s2_r;
        end
    end
endmodule : nrt_switch_end
